// >>> pkg/icache_regs.svh
// Purpose: Constants for the instruction cache fetch, replacement and lockdown block
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   Offsets are APB byte addresses; counts are in words
// Function
// - Disabled cache: each fetch single nonsequential access
// - Enabled cache: look up every fetch
// - Cachable hit returns cached word, no bus
// - Cachable miss fills a whole eight-word line
// - Victim chosen among unlocked entries, selected policy
// - Noncachable fetch: one nonsequential access, no allocation
// - Noncachable hit is a software error, unspecified
// - Control bit 14 picks policy; reset random
// - Round-robin runs an own sequence per segment
// - Invalidate whole cache or one line by address
// - Lockdown write forces the victim pointer
// - Prefetch op looks up, fills victim on miss
// - Victims limited to lockdown base up to 63
// - Lockdown field starts at bit 26
// - Prefetch operand used as modified virtual address
// - Prefetch accepts unaligned addresses
// - Segment taken from address mask 0xE0
// - Eight segments from bits 7..5, 64 lines each
// - Hit compares address bits 31..8 with tag
// - Reset invalidates all entries and disables cache
// - Control bit 12 enables the cache
`ifndef ICACHE_REGS_SVH
`define ICACHE_REGS_SVH

// ==========================================================
// Register offsets
`define OFS_CTRL     12'h000
`define OFS_LOCK     12'h004
`define OFS_INV_ALL  12'h008
`define OFS_INV_LINE 12'h00C
`define OFS_PREFETCH 12'h010
`define OFS_STATUS   12'h014

// ==========================================================
// Field positions and reset values
`define CTRL_EN_BIT   12
`define CTRL_RR_BIT   14
`define LOCK_LSB      26
`define CTRL_RESET    32'h0000_0000
`define LFSR_SEED     6'h01
`define LAST_INDEX    6'h3F
`define WORDS_PER_LINE 8

`endif

// >>> pkg/icache_pkg.sv
// Purpose: Types shared by the instruction cache block
// Assumes: Eight segments of 64 lines of eight words
// Notes:   Constants live in icache_regs.svh
package icache_pkg;
  typedef enum {S_IDLE, S_FILL, S_SINGLE} state_t;
  typedef logic [5:0]  index_t;
  typedef logic [2:0]  seg_t;
  typedef logic [23:0] tag_t;
endpackage

// >>> core/line_store.sv
// Purpose: Data array of the instruction cache
// Assumes: One write port, one combinational read port
// Notes:   No reset; valid bits elsewhere guard the contents
`timescale 1ns/1ns
module line_store #(
  parameter int AW = 12
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  logic [31:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// >>> core/icache_fetch_replace_lockdown.sv
// Purpose: Instruction fetch hit, linefill and uncached paths with victim selection and lockdown
// Assumes: Core holds fetch_req and fetch_addr until fetch_valid; bus holds each beat until bus_ack
// Notes:   Maintenance and prefetch operations are APB writes that stall while a fill runs
`timescale 1ns/1ns
`include "icache_regs.svh"
module icache_fetch_replace_lockdown #(
  parameter int WAYS = 64,
  parameter int SEGS = 8
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Core fetch port
  input  wire logic          fetch_req,
  input  wire logic [31:0]   fetch_addr,
  input  wire logic          fetch_cachable,
  output logic               fetch_valid,
  output logic      [31:0]   fetch_rdata,
  // System bus
  output logic               bus_req,
  output logic      [31:0]   bus_addr,
  output logic               bus_seq,
  input  wire logic          bus_ack,
  input  wire logic [31:0]   bus_rdata
);
  import icache_pkg::*;

  localparam int LINES = WAYS * SEGS;

  // ==========================================================
  // State
  state_t              state_q, state_d;
  logic                en_q, en_d;
  logic                rr_q, rr_d;
  index_t              base_q, base_d;
  index_t              vict_q [SEGS];
  index_t              vict_d [SEGS];
  logic [SEGS-1:0]     force_q, force_d;
  logic [5:0]          lfsr_q, lfsr_d;
  logic [LINES-1:0]    valid_q, valid_d;
  tag_t                tag_q [LINES];
  logic                tag_we;
  logic [8:0]          tag_wa;
  logic [31:0]         line_q, line_d;
  index_t              fill_idx_q, fill_idx_d;
  logic [2:0]          beat_q, beat_d;
  logic                pf_q, pf_d;
  logic                breq_q, breq_d;
  logic [31:0]         baddr_q, baddr_d;
  logic                bseq_q, bseq_d;
  logic                fv_q, fv_d;
  logic [31:0]         frd_q, frd_d;
  logic [31:0]         last_pf_q, last_pf_d;

  // ==========================================================
  // APB decode
  logic apb_acc;
  logic apb_wr;
  logic is_op;
  logic op_go;
  logic ctrl_wr;
  logic lock_wr;

  assign apb_acc = psel & penable;
  assign apb_wr  = apb_acc & pwrite;
  assign is_op   = (paddr == `OFS_INV_ALL) | (paddr == `OFS_INV_LINE) | (paddr == `OFS_PREFETCH);
  // Operations wait for the engine so a fill never sees its victim move under it
  assign pready  = ~(psel & pwrite & is_op & (state_q != S_IDLE));
  assign op_go   = apb_wr & is_op & pready;
  assign ctrl_wr = apb_wr & (paddr == `OFS_CTRL);
  assign lock_wr = apb_wr & (paddr == `OFS_LOCK);

  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    if (apb_acc) begin
      unique case (paddr)
        `OFS_CTRL: begin
          prdata[`CTRL_EN_BIT] = en_q;
          prdata[`CTRL_RR_BIT] = rr_q;
        end
        `OFS_LOCK: begin
          prdata[31:`LOCK_LSB] = base_q;
        end
        `OFS_STATUS: begin
          prdata[0]   = (state_q != S_IDLE);
          prdata[1]   = pf_q;
          prdata[2]   = en_q;
          prdata[5:3] = last_pf_q[7:5];
          prdata[13:8] = fill_idx_q;
        end
        `OFS_INV_ALL, `OFS_INV_LINE, `OFS_PREFETCH: begin
          prdata = 32'h0000_0000;
        end
        default: begin
          pslverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Lookup
  logic [31:0] look_addr;
  seg_t        look_seg;
  tag_t        look_tag;
  logic        hit;
  index_t      hit_way;

  // A pending operation owns the lookup port; its operand is used as given, with no aliasing
  assign look_addr = op_go ? pwdata : fetch_addr;
  assign look_seg  = look_addr[7:5];
  assign look_tag  = look_addr[31:8];

  always_comb begin
    hit     = 1'b0;
    hit_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[{look_seg, 6'(w)}] && (tag_q[{look_seg, 6'(w)}] == look_tag)) begin
        hit     = 1'b1;
        hit_way = 6'(w);
      end
    end
  end

  // ==========================================================
  // Victim choice
  index_t rnd_idx;
  index_t victim;

  // Values below the base fold onto the base; slight bias traded for one comparator
  assign rnd_idx = (lfsr_q < base_q) ? base_q : lfsr_q;
  always_comb begin
    if (force_q[look_seg] || rr_q) begin
      victim = (vict_q[look_seg] < base_q) ? base_q : vict_q[look_seg];
    end else begin
      victim = rnd_idx;
    end
  end

  // ==========================================================
  // Data array
  logic        st_we;
  logic [11:0] st_wa;
  logic [11:0] st_ra;
  logic [31:0] st_rd;

  assign st_we = (state_q == S_FILL) & bus_ack;
  assign st_wa = {line_q[7:5], fill_idx_q, beat_q};
  assign st_ra = {look_seg, hit_way, look_addr[4:2]};

  line_store #(
    .AW(12)
  ) u_store (
    .clk   (pclk),
    .we    (st_we),
    .waddr (st_wa),
    .wdata (bus_rdata),
    .raddr (st_ra),
    .rdata (st_rd)
  );

  // ==========================================================
  // Control registers and lockdown
  always_comb begin
    en_d    = en_q;
    rr_d    = rr_q;
    base_d  = base_q;
    vict_d  = vict_q;
    force_d = force_q;
    lfsr_d  = {lfsr_q[4:0], lfsr_q[5] ^ lfsr_q[4]};
    if (ctrl_wr) begin
      en_d = pwdata[`CTRL_EN_BIT];
      rr_d = pwdata[`CTRL_RR_BIT];
    end
    if (lock_wr) begin
      base_d  = pwdata[31:`LOCK_LSB];
      force_d = '1;
      for (int s = 0; s < SEGS; s++) begin
        vict_d[s] = pwdata[31:`LOCK_LSB];
      end
    end else if (st_we && (beat_q == 3'(`WORDS_PER_LINE - 1))) begin
      force_d[line_q[7:5]] = 1'b0;
      // Advance only the segment that filled, wrapping to the base
      if (fill_idx_q == `LAST_INDEX) begin
        vict_d[line_q[7:5]] = base_q;
      end else begin
        vict_d[line_q[7:5]] = fill_idx_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // Fetch and fill engine
  always_comb begin
    state_d    = state_q;
    valid_d    = valid_q;
    tag_we     = 1'b0;
    tag_wa     = {line_q[7:5], fill_idx_q};
    line_d     = line_q;
    fill_idx_d = fill_idx_q;
    beat_d     = beat_q;
    pf_d       = pf_q;
    breq_d     = breq_q;
    baddr_d    = baddr_q;
    bseq_d     = bseq_q;
    fv_d       = 1'b0;
    frd_d      = frd_q;
    last_pf_d  = last_pf_q;
    unique case (state_q)
      S_IDLE: begin
        if (op_go) begin
          if (paddr == `OFS_INV_ALL) begin
            valid_d = '0;
          end else if (paddr == `OFS_INV_LINE) begin
            if (hit) begin
              valid_d[{look_seg, hit_way}] = 1'b0;
            end
          end else begin
            last_pf_d = pwdata;
            // Prefetch fills only on a miss, into the chosen victim
            if (!hit) begin
              valid_d[{look_seg, victim}] = 1'b0;
              line_d     = {pwdata[31:5], 5'h00};
              fill_idx_d = victim;
              beat_d     = 3'h0;
              pf_d       = 1'b1;
              breq_d     = 1'b1;
              baddr_d    = {pwdata[31:5], 5'h00};
              bseq_d     = 1'b0;
              state_d    = S_FILL;
            end
          end
        end else if (fetch_req && !fv_q) begin
          if (!en_q || !fetch_cachable) begin
            // Hits in noncachable space are ignored and go to the bus as well
            line_d  = fetch_addr;
            breq_d  = 1'b1;
            baddr_d = {fetch_addr[31:2], 2'b00};
            bseq_d  = 1'b0;
            state_d = S_SINGLE;
          end else if (hit) begin
            fv_d  = 1'b1;
            frd_d = st_rd;
          end else begin
            valid_d[{look_seg, victim}] = 1'b0;
            line_d     = fetch_addr;
            fill_idx_d = victim;
            beat_d     = 3'h0;
            pf_d       = 1'b0;
            breq_d     = 1'b1;
            baddr_d    = {fetch_addr[31:5], 5'h00};
            bseq_d     = 1'b0;
            state_d    = S_FILL;
          end
        end
      end
      S_FILL: begin
        if (bus_ack) begin
          if (!pf_q && (beat_q == line_q[4:2])) begin
            frd_d = bus_rdata;
          end
          if (beat_q == 3'(`WORDS_PER_LINE - 1)) begin
            tag_we  = 1'b1;
            valid_d[{line_q[7:5], fill_idx_q}] = 1'b1;
            breq_d  = 1'b0;
            bseq_d  = 1'b0;
            fv_d    = ~pf_q;
            pf_d    = 1'b0;
            state_d = S_IDLE;
          end else begin
            beat_d  = beat_q + 3'h1;
            baddr_d = {line_q[31:5], beat_q + 3'h1, 2'b00};
            bseq_d  = 1'b1;
          end
        end
      end
      S_SINGLE: begin
        if (bus_ack) begin
          breq_d  = 1'b0;
          fv_d    = 1'b1;
          frd_d   = bus_rdata;
          state_d = S_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= S_IDLE;
      en_q       <= 1'b0;
      rr_q       <= 1'b0;
      base_q     <= '0;
      force_q    <= '0;
      lfsr_q     <= `LFSR_SEED;
      valid_q    <= '0;
      line_q     <= 32'h0000_0000;
      fill_idx_q <= '0;
      beat_q     <= 3'h0;
      pf_q       <= 1'b0;
      breq_q     <= 1'b0;
      baddr_q    <= 32'h0000_0000;
      bseq_q     <= 1'b0;
      fv_q       <= 1'b0;
      frd_q      <= 32'h0000_0000;
      last_pf_q  <= 32'h0000_0000;
      for (int s = 0; s < SEGS; s++) begin
        vict_q[s] <= '0;
      end
    end else begin
      state_q    <= state_d;
      en_q       <= en_d;
      rr_q       <= rr_d;
      base_q     <= base_d;
      force_q    <= force_d;
      lfsr_q     <= lfsr_d;
      valid_q    <= valid_d;
      line_q     <= line_d;
      fill_idx_q <= fill_idx_d;
      beat_q     <= beat_d;
      pf_q       <= pf_d;
      breq_q     <= breq_d;
      baddr_q    <= baddr_d;
      bseq_q     <= bseq_d;
      fv_q       <= fv_d;
      frd_q      <= frd_d;
      last_pf_q  <= last_pf_d;
      vict_q     <= vict_d;
    end
  end

  // Tags need no reset; valid bits decide whether they count
  always_ff @(posedge pclk) begin
    if (tag_we) begin
      tag_q[tag_wa] <= line_q[31:8];
    end
  end

  // ==========================================================
  // Outputs
  assign fetch_valid = fv_q;
  assign fetch_rdata = frd_q;
  assign bus_req     = breq_q;
  assign bus_addr    = baddr_q;
  assign bus_seq     = bseq_q;
endmodule

// >>> bench/sys_mem_model.sv
// Purpose: System bus memory seen by the icache block
// Assumes: Word data is the beat address xor key
// Notes:   Idle data toggles so stale values never pass
`timescale 1ns/1ns
module sys_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bus
  input  wire logic        bus_req,
  input  wire logic [31:0] bus_addr,
  output logic             bus_ack,
  output logic      [31:0] bus_rdata,
  // Control
  input  wire logic [31:0] key,
  input  wire logic        slow
);
  logic [1:0] wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ack <= 1'b0;
      wait_q <= 2'h0;
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack) begin
        if (wait_q >= (slow ? 2'h3 : 2'h0)) begin
          bus_ack <= 1'b1;
          bus_rdata <= bus_addr ^ key;
          wait_q <= 2'h0;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule

// >>> bench/icache_fetch_replace_lockdown_sva.sv
// Purpose: Port checks for the icache block
// Assumes: Enable tracked from taken CTRL writes
// Notes:   Bench overlaps fetches with APB traffic only for status reads
`timescale 1ns/1ns
`include "icache_regs.svh"
module icache_fetch_replace_lockdown_sva #(
  parameter int WAYS = 64,
  parameter int SEGS = 8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Fetch and bus
  input wire logic        fetch_req,
  input wire logic        fetch_cachable,
  input wire logic        fetch_valid,
  input wire logic        bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_seq,
  input wire logic        bus_ack
);
  logic en_q;
  logic en_d;
  always_comb begin
    en_d = en_q;
    if (psel && penable && pready && pwrite && paddr == `OFS_CTRL) begin
      en_d = pwdata[`CTRL_EN_BIT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_disabled_single: assert property (!en_q && bus_req |-> !bus_seq)
    else $error("burst beat while disabled");
  chk_beat_hold: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_seq))
    else $error("beat dropped before ack");
  chk_beat_step: assert property (bus_req && bus_ack && bus_seq && bus_addr[4:2] != 3'h7
    |=> bus_req && bus_seq && bus_addr == $past(bus_addr) + 32'h0000_0004)
    else $error("fill beat order wrong");
  chk_fill_end: assert property (bus_req && bus_ack && bus_seq && bus_addr[4:2] == 3'h7 |=> !bus_req)
    else $error("fill longer than a line");
  chk_single_done: assert property (fetch_req && !fetch_cachable && bus_req && bus_ack
    |=> !bus_req && fetch_valid)
    else $error("uncached fetch not single");
  chk_fetch_answer: assert property (fetch_req && !fetch_valid && !bus_req && !psel
    |=> fetch_valid || bus_req)
    else $error("fetch not looked up");
  chk_op_stall: assert property (psel && penable && !pready
    |-> pwrite && paddr inside {`OFS_INV_ALL, `OFS_INV_LINE, `OFS_PREFETCH})
    else $error("stall on other access");
  chk_reset_quiet: assert property ($rose(presetn) |-> !bus_req && !fetch_valid)
    else $error("activity after reset");
endmodule
bind icache_fetch_replace_lockdown icache_fetch_replace_lockdown_sva #(.WAYS(WAYS), .SEGS(SEGS)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .fetch_req(fetch_req), .fetch_cachable(fetch_cachable),
  .fetch_valid(fetch_valid), .bus_req(bus_req), .bus_addr(bus_addr), .bus_seq(bus_seq), .bus_ack(bus_ack));

// >>> bench/icache_fetch_replace_lockdown_tb.sv
// Purpose: Self-checking bench for the icache block
// Assumes: Memory word is address xor key
// Notes:   Slow memory lets status be read mid-fill
`timescale 1ns/1ns
`include "icache_regs.svh"
module icache_fetch_replace_lockdown_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, fetch_valid, bus_req, bus_seq, bus_ack, er;
  logic        fetch_req = 1'b0, fetch_cachable = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, fetch_addr = '0, key = '0, beats = '0;
  logic [31:0] prdata, fetch_rdata, bus_addr, bus_rdata, rd;
  int          errors = 0, checks_done = 0;
  always #5 pclk = ~pclk;
  icache_fetch_replace_lockdown i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_cachable(fetch_cachable),
    .fetch_valid(fetch_valid), .fetch_rdata(fetch_rdata), .bus_req(bus_req), .bus_addr(bus_addr),
    .bus_seq(bus_seq), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  sys_mem_model i_mem (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_addr(bus_addr),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .key(key), .slow(slow));
  always @(posedge pclk) if (bus_req && bus_ack) beats <= beats + 1;
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("BAD %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Transfer is taken at the rising edge that samples pready high; data is captured there, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic fetch(input logic [31:0] a, input logic c, input logic [31:0] k, input logic [31:0] nb);
    logic [31:0] d;
    logic [31:0] b0;
    @(posedge pclk);
    b0 = beats;
    fetch_req <= 1'b1;
    fetch_addr <= a;
    fetch_cachable <= c;
    do @(posedge pclk); while (fetch_valid !== 1'b1);
    d = fetch_rdata;
    fetch_req <= 1'b0;
    cmp(d, {a[31:2], 2'b00} ^ k);
    cmp(beats - b0, nb);
  endtask
  task automatic fill(input logic [31:0] a, input logic [5:0] lo, input logic [5:0] hi);
    logic [31:0] s;
    logic e;
    fork
      fetch(a, 1'b1, key, 32'h0000_0008);
      begin repeat (4) @(posedge pclk); apb(1'b0, `OFS_STATUS, '0, s, e); end
    join
    cmp(32'(s[13:8] >= lo && s[13:8] <= hi), 32'h0000_0001);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("BAD %0t: watchdog expired", $time);
    conclude;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CTRL, '0, rd, er);
    cmp(rd, 32'h0000_0000);
    apb(1'b0, `OFS_STATUS, '0, rd, er);
    cmp(rd & 32'h0000_0007, 32'h0000_0000);
    apb(1'b0, 12'h0F0, '0, rd, er);
    cmp(32'(er), 32'h0000_0001);
    key = 32'h1111_0000;
    fetch(32'h0000_1040, 1'b1, key, 1);
    fetch(32'h0000_1040, 1'b1, key, 1);
    wr(`OFS_CTRL, 32'h0000_1000);
    fetch(32'h0000_1040, 1'b1, key, 8);
    key = 32'h2222_0000;
    fetch(32'h0000_1044, 1'b1, 32'h1111_0000, 0);
    wr(`OFS_INV_LINE, 32'h0000_1044);
    fetch(32'h0000_1040, 1'b1, key, 8);
    wr(`OFS_INV_ALL, '0);
    fetch(32'h0000_1048, 1'b1, key, 8);
    key = 32'h1111_0000;
    fetch(32'h0000_1044, 1'b0, key, 1);
    fetch(32'h0000_2000, 1'b0, key, 1);
    fetch(32'h0000_2000, 1'b1, key, 8);
    fetch(32'h0000_1140, 1'b1, key, 8);
    slow = 1'b1;
    wr(`OFS_LOCK, 32'h1400_0000);
    wr(`OFS_PREFETCH, 32'h0000_3063);
    apb(1'b0, `OFS_STATUS, '0, rd, er);
    cmp(32'(rd[13:8]), 32'h0000_0005);
    cmp(32'(rd[5:3]), 32'h0000_0003);
    cmp(32'(rd[1]), 32'h0000_0001);
    // A second operation during the fill stalls, then hits and leaves the engine idle
    wr(`OFS_PREFETCH, 32'h0000_3063);
    apb(1'b0, `OFS_STATUS, '0, rd, er);
    cmp(rd & 32'h0000_0003, 32'h0000_0000);
    fetch(32'h0000_3068, 1'b1, key, 0);
    wr(`OFS_CTRL, 32'h0000_5000);
    wr(`OFS_LOCK, 32'hF800_0000);
    fill(32'h0010_0000, 62, 62);
    fill(32'h0010_0100, 63, 63);
    fill(32'h0010_0220, 62, 62);
    fill(32'h0010_0300, 62, 62);
    wr(`OFS_CTRL, 32'h0000_1000);
    wr(`OFS_LOCK, 32'hF000_0000);
    for (int i = 0; i < 6; i++) fill(32'h0020_0040 + 32'(i << 8), 60, 63);
    conclude;
  end
endmodule
